// [hw/fsq_pkg.sv]
// package: constants and carrier types for the read-family sequencer
package fsq_pkg;

  localparam int unsigned CMD_PARAM_BYTES = 8;
  localparam int unsigned RES_BYTES       = 7;
  localparam logic [3:0]  LAST_PARAM_IDX  = 4'h8;
  localparam logic [3:0]  LAST_RES_IDX    = 4'h6;

  // opcode byte fields
  localparam int unsigned OP_MULTI_BIT  = 7;
  localparam int unsigned OP_CODING_BIT = 6;
  localparam int unsigned OP_SKIP_BIT   = 5;
  localparam logic [4:0]  OP_READ_DATA = 5'h06;
  localparam logic [4:0]  OP_READ_DEL  = 5'h0c;
  localparam logic [5:0]  OP_READ_TRK  = 6'h02;

  // select byte fields
  localparam int unsigned SEL_HEAD_BIT   = 2;
  localparam int unsigned SEL_DRV_HI_BIT = 1;
  localparam int unsigned SEL_DRV_LO_BIT = 0;

  // parameter byte positions after the opcode
  localparam int unsigned P_SELECT = 0;
  localparam int unsigned P_CYL    = 1;
  localparam int unsigned P_HEAD   = 2;
  localparam int unsigned P_REC    = 3;
  localparam int unsigned P_SIZE   = 4;
  localparam int unsigned P_FINAL  = 5;
  localparam int unsigned P_GAP    = 6;
  localparam int unsigned P_DLEN   = 7;

  typedef enum logic [1:0]
  {
    FSQ_CMD  = 2'b00,
    FSQ_EXEC = 2'b01,
    FSQ_RES  = 2'b11
  } fsq_phase_e;

  typedef enum logic [1:0]
  {
    FSQ_K_NONE  = 2'b00,
    FSQ_K_DATA  = 2'b01,
    FSQ_K_DEL   = 2'b10,
    FSQ_K_TRACK = 2'b11
  } fsq_kind_e;

  typedef struct packed
  {
    fsq_kind_e  kind;
    logic       multi_track_flag;
    logic       double_density_coding;
    logic       bypass_deleted_sectors;
    logic       head_select;
    logic       drive_select_high;
    logic       drive_select_low;
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] record;
    logic [7:0] size_code;
    logic [7:0] final_sector_number;
    logic [7:0] gap_length_value;
    logic [7:0] data_length_value;
  } fsq_cmd_s;

  typedef struct packed
  {
    logic [7:0] result_status_zero;
    logic [7:0] result_status_one;
    logic [7:0] result_status_two;
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] record;
    logic [7:0] size_code;
  } fsq_res_s;

  function automatic fsq_kind_e fsq_decode(input logic [7:0] op);
    fsq_kind_e k;
    k = FSQ_K_NONE;
    if (op[4:0] == OP_READ_DATA)
      k = FSQ_K_DATA;
    else if (op[4:0] == OP_READ_DEL)
      k = FSQ_K_DEL;
    else if (!op[OP_MULTI_BIT] && op[5:0] == OP_READ_TRK)
      k = FSQ_K_TRACK;
    return k;
  endfunction

endpackage

// [hw/fsq_sequencer.sv]
// module: command, execution and result sequencing for read commands
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - top bits multi-track, coding, skip; low five 00110 read, 01100 deleted
// - track read: bit7 0, bit6 coding, low six 000010; index to final sector
// - next: select, cylinder, head, record, size, final sector, gap, length
// - sector bytes pass drive to host one by one before results
// - seven result bytes: three status, then cylinder, head, record, size
// - skip flag set: read data passes over deleted-marked sectors, read deleted passes over unmarked ones; not transferred
// - phases run strictly command, execution, result
// - drive select bits choose the addressed drive
module fsq_sequencer
  import fsq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic [7:0] host_wdata_i,
  output logic      [7:0] host_rdata_o,
  output logic            host_request_ready_o,
  output logic            transfer_direction_o,
  output logic            exec_phase_o,
  output logic            op_start_o,
  output fsq_cmd_s        cmd_o,
  output logic      [1:0] drive_select_o,
  input  wire logic       disk_valid_i,
  input  wire logic [7:0] disk_byte_i,
  input  wire logic       disk_deleted_i,
  output logic            disk_ready_o,
  input  wire logic       op_done_i,
  input  wire fsq_res_s   res_i
);

  typedef struct packed
  {
    fsq_phase_e      phase;
    logic [3:0]      cnt;
    logic [7:0]      opcode;
    logic [7:0][7:0] params;
    logic [7:0]      hold;
    logic            hold_full;
    logic            done_seen;
    logic [6:0][7:0] results;
    logic            start;
  } fsq_state_s;

  fsq_state_s st;
  fsq_state_s next_st;

  fsq_kind_e  kind;
  logic       wr_ok;
  logic       rd_ok;
  logic       take;
  logic       skip;

  assign kind  = fsq_decode(st.opcode);
  // host handshake: ready means a write is taken in command phase and a
  // read is taken when a byte is waiting in execution or result phase
  assign host_request_ready_o = (st.phase == FSQ_CMD) ||
                                (st.phase == FSQ_RES) ||
                                (st.phase == FSQ_EXEC && st.hold_full);
  assign transfer_direction_o = (st.phase != FSQ_CMD);
  assign exec_phase_o         = (st.phase == FSQ_EXEC);
  assign wr_ok = host_wr_i && st.phase == FSQ_CMD;
  assign rd_ok = host_rd_i && host_request_ready_o && transfer_direction_o;
  // single holding byte: the drive side stalls until the host empties it
  assign disk_ready_o = (st.phase == FSQ_EXEC) && !st.hold_full;
  assign take = disk_valid_i && disk_ready_o;
  always_comb
  begin
    skip = 1'b0;
    if (cmd_o.bypass_deleted_sectors)
    begin
      if (kind == FSQ_K_DATA)
        skip = disk_deleted_i;
      else if (kind == FSQ_K_DEL)
        skip = !disk_deleted_i;
    end
  end

  always_comb
  begin
    next_st       = st;
    next_st.start = 1'b0;
    unique case (st.phase)
      FSQ_CMD:
      begin
        if (wr_ok)
        begin
          if (st.cnt == 4'h0)
          begin
            // unknown opcodes are dropped; this block serves reads only
            if (fsq_decode(host_wdata_i) != FSQ_K_NONE)
            begin
              next_st.opcode = host_wdata_i;
              next_st.cnt    = 4'h1;
            end
          end
          else
          begin
            next_st.params[st.cnt[2:0] - 3'h1] = host_wdata_i;
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == LAST_PARAM_IDX)
            begin
              next_st.phase     = FSQ_EXEC;
              next_st.cnt       = 4'h0;
              next_st.start     = 1'b1;
              next_st.hold_full = 1'b0;
              next_st.done_seen = 1'b0;
            end
          end
        end
      end
      FSQ_EXEC:
      begin
        if (take && !skip)
        begin
          next_st.hold      = disk_byte_i;
          next_st.hold_full = 1'b1;
        end
        else if (rd_ok)
          next_st.hold_full = 1'b0;
        if (op_done_i)
        begin
          next_st.done_seen = 1'b1;
          next_st.results   = {res_i.size_code, res_i.record, res_i.head,
                               res_i.cylinder, res_i.result_status_two,
                               res_i.result_status_one,
                               res_i.result_status_zero};
        end
        // results wait until the last sector byte has left the hold
        if (st.done_seen && !st.hold_full)
          next_st.phase = FSQ_RES;
      end
      FSQ_RES:
      begin
        if (rd_ok)
        begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt == LAST_RES_IDX)
          begin
            next_st.phase = FSQ_CMD;
            next_st.cnt   = 4'h0;
          end
        end
      end
      default:
      begin
        next_st.phase = FSQ_CMD;
        next_st.cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      st <= '0;
    else
      st <= next_st;
  end

  always_comb
  begin
    host_rdata_o = 8'h00;
    if (st.phase == FSQ_EXEC)
      host_rdata_o = st.hold;
    else if (st.phase == FSQ_RES)
      host_rdata_o = st.results[st.cnt[2:0]];
  end

  assign op_start_o = st.start;
  always_comb
  begin
    cmd_o                        = '0;
    cmd_o.kind                   = kind;
    cmd_o.multi_track_flag       = st.opcode[OP_MULTI_BIT];
    cmd_o.double_density_coding  = st.opcode[OP_CODING_BIT];
    cmd_o.bypass_deleted_sectors = (kind != FSQ_K_TRACK) &&
                                   st.opcode[OP_SKIP_BIT];
    if (kind == FSQ_K_TRACK)
      cmd_o.multi_track_flag = 1'b0;
    cmd_o.head_select         = st.params[P_SELECT][SEL_HEAD_BIT];
    cmd_o.drive_select_high   = st.params[P_SELECT][SEL_DRV_HI_BIT];
    cmd_o.drive_select_low    = st.params[P_SELECT][SEL_DRV_LO_BIT];
    cmd_o.cylinder            = st.params[P_CYL];
    cmd_o.head                = st.params[P_HEAD];
    cmd_o.record              = st.params[P_REC];
    cmd_o.size_code           = st.params[P_SIZE];
    cmd_o.final_sector_number = st.params[P_FINAL];
    cmd_o.gap_length_value    = st.params[P_GAP];
    cmd_o.data_length_value   = st.params[P_DLEN];
  end
  assign drive_select_o = {cmd_o.drive_select_high,
                           cmd_o.drive_select_low};

  sequence s_last_write;
    st.phase == FSQ_CMD && wr_ok && st.cnt == LAST_PARAM_IDX;
  endsequence

  sequence s_last_read;
    st.phase == FSQ_RES && rd_ok && st.cnt == LAST_RES_IDX;
  endsequence

  a_exec_after_nine: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(exec_phase_o) |-> $past(wr_ok) && $past(st.cnt) == LAST_PARAM_IDX)
    else $error("execution entered before ninth command byte");

  a_nine_starts: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_last_write |=> op_start_o && exec_phase_o ##1 !op_start_o)
    else $error("ninth byte did not start execution");

  a_idle_after_seven: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_last_read |=> st.phase == FSQ_CMD && st.cnt == 4'h0)
    else $error("not idle after seventh result read");

  a_start_legal_op: assert property (
    @(posedge clk_i) disable iff (reset_i)
    op_start_o |-> cmd_o.kind != FSQ_K_NONE)
    else $error("execution started for unknown opcode");

  // checked against the written byte, not the stored copy it comes from
  a_drive_select: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_ok && st.cnt == 4'h1
      |=> drive_select_o == $past({host_wdata_i[SEL_DRV_HI_BIT],
                                   host_wdata_i[SEL_DRV_LO_BIT]}))
    else $error("drive select does not follow select byte");

  a_skip_deleted: assert property (
    @(posedge clk_i) disable iff (reset_i)
    take && skip |=> !st.hold_full)
    else $error("skipped sector byte reached the host");

  a_pass_byte: assert property (
    @(posedge clk_i) disable iff (reset_i)
    take && !skip |=> st.hold_full && host_rdata_o == $past(disk_byte_i))
    else $error("sector byte not presented to host");

  a_result_waits: assert property (
    @(posedge clk_i) disable iff (reset_i)
    exec_phase_o && st.hold_full |=> st.phase != FSQ_RES)
    else $error("result phase entered with byte pending");

  a_result_step: assert property (
    @(posedge clk_i) disable iff (reset_i)
    st.phase == FSQ_RES && rd_ok && st.cnt != LAST_RES_IDX
      |=> st.cnt == $past(st.cnt) + 4'h1 && st.phase == FSQ_RES)
    else $error("result byte order broken");

  a_result_entry: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(st.phase == FSQ_RES) |-> $past(st.done_seen) && $past(exec_phase_o)
      && st.cnt == 4'h0 && host_request_ready_o && transfer_direction_o)
    else $error("result phase entered out of order");

endmodule

`default_nettype wire

// [tb/fsq_drive_model.sv]
// drive-side model: sector bytes with delete marks, then results
`timescale 1ns/100ps
`default_nettype none
module fsq_drive_model
  import fsq_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     start_i,
  input  wire logic     disk_ready_i,
  input  wire fsq_cmd_s cmd_i,
  output logic          disk_valid_o,
  output logic    [7:0] disk_byte_o,
  output logic          disk_deleted_o,
  output logic          op_done_o,
  output fsq_res_s      res_o
);
  int i;
  initial
  begin
    disk_valid_o = 1'b0;
    disk_byte_o = 8'h00;
    disk_deleted_o = 1'b0;
    op_done_o = 1'b0;
    res_o = '0;
    forever
    begin
      @(posedge clk_i);
      if (start_i)
      begin
        // six bytes per command, every other one delete-marked
        for (i = 0; i < 6; i++)
        begin
          repeat ($urandom_range(0, 3)) @(posedge clk_i);
          #1;
          disk_valid_o = 1'b1;
          disk_byte_o = cmd_i.cylinder + 8'(i);
          disk_deleted_o = i[0];
          do @(posedge clk_i); while (!disk_ready_i);
          #1;
          disk_valid_o = 1'b0;
          // a released byte lane shows garbage, not the last value
          disk_byte_o = ~disk_byte_o;
          disk_deleted_o = ~disk_deleted_o;
        end
        res_o = {{5'h00, cmd_i.head_select, cmd_i.drive_select_high,
                  cmd_i.drive_select_low}, 8'h00, 8'h00, cmd_i.cylinder,
                 cmd_i.head, cmd_i.final_sector_number, cmd_i.size_code};
        op_done_o = 1'b1;
        @(posedge clk_i);
        #1;
        op_done_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// testbench: host-side driver with queued checks on the sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fsq_pkg::*;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       host_wr_i = 1'b0;
  logic       host_rd_i = 1'b0;
  logic [7:0] host_wdata_i = 8'h00;
  logic [7:0] host_rdata_o;
  logic       host_request_ready_o, transfer_direction_o;
  logic       exec_phase_o, op_start_o, disk_ready_o;
  logic       disk_valid_i, disk_deleted_i, op_done_i;
  logic [1:0] drive_select_o;
  logic [7:0] disk_byte_i;
  fsq_cmd_s   cmd_o;
  fsq_res_s   res_i;
  logic [7:0] exp_q [$];
  int         n_fail = 0;
  int         check_count = 0;
  int         i;

  fsq_sequencer u_fsq_sequencer (.clk_i(clk_i), .reset_i(reset_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_request_ready_o(host_request_ready_o),
    .transfer_direction_o(transfer_direction_o),
    .exec_phase_o(exec_phase_o), .op_start_o(op_start_o), .cmd_o(cmd_o),
    .drive_select_o(drive_select_o), .disk_valid_i(disk_valid_i),
    .disk_byte_i(disk_byte_i), .disk_deleted_i(disk_deleted_i),
    .disk_ready_o(disk_ready_o), .op_done_i(op_done_i), .res_i(res_i));

  fsq_drive_model u_fsq_drive_model (.clk_i(clk_i), .start_i(op_start_o),
    .disk_ready_i(disk_ready_o), .cmd_i(cmd_o), .disk_valid_o(disk_valid_i),
    .disk_byte_o(disk_byte_i), .disk_deleted_o(disk_deleted_i),
    .op_done_o(op_done_i), .res_o(res_i));

  always #5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_for(input logic dir);
    int n;
    n = 0;
    while (!(host_request_ready_o === 1'b1 && transfer_direction_o === dir))
    begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 300)
      begin
        n_fail++;
        close_out();
      end
    end
  endtask

  // strobe left high between back-to-back writes; caller drops it
  task automatic put(input logic [7:0] b);
    wait_for(1'b0);
    host_wr_i = 1'b1;
    host_wdata_i = b;
    @(posedge clk_i);
    #1;
  endtask

  task automatic get();
    wait_for(1'b1);
    host_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    host_rd_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  always @(posedge clk_i)
    if (host_rd_i)
      check(host_rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

  task automatic run_cmd(input int k, input logic sk);
    logic [7:0]  p [8];
    logic [7:0]  op;
    logic [63:0] e;
    fsq_kind_e   ek;
    int          n;
    foreach (p[j]) p[j] = 8'($urandom);
    p[P_SELECT][7:3] = 5'h00;
    op = 8'($urandom);
    op[5:0] = {sk, k == 0 ? OP_READ_DATA : OP_READ_DEL};
    if (k == 2) op = {1'b0, op[6], OP_READ_TRK};
    ek = k == 0 ? FSQ_K_DATA : k == 1 ? FSQ_K_DEL : FSQ_K_TRACK;
    // decoded command bytes from those sent; the 64-bit e also holds kind, flag and select bits
    e = {ek, op[7], op[6], sk && k != 2, p[P_SELECT][2:0], p[P_CYL],
         p[P_HEAD], p[P_REC], p[P_SIZE], p[P_FINAL], p[P_GAP], p[P_DLEN]};
    put(op);
    foreach (p[j]) put(p[j]);
    host_wr_i = 1'b0;
    check({exec_phase_o, op_start_o, transfer_direction_o}, 3'b111);
    check({disk_ready_o, host_request_ready_o}, 2'b10);
    check(drive_select_o, p[P_SELECT][1:0]);
    check(cmd_o.kind, ek);
    check(cmd_o.multi_track_flag, op[7]);
    check(cmd_o.final_sector_number, p[P_FINAL]);
    check(cmd_o[63:32], e[63:32]);
    check(cmd_o[31:0], e[31:0]);
    for (n = 0; n < 6; n++)
      if (k == 2 || !sk || n[0] == (k == 1))
        exp_q.push_back(p[P_CYL] + 8'(n));
    exp_q.push_back({5'h00, p[P_SELECT][2:0]});
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(p[P_CYL]);
    exp_q.push_back(p[P_HEAD]);
    exp_q.push_back(p[P_FINAL]);
    exp_q.push_back(p[P_SIZE]);
    repeat (exp_q.size()) get();
    check(exp_q.size(), 0);
    check({transfer_direction_o, exec_phase_o}, 2'b00);
  endtask

  initial
  begin
    void'($urandom(32'h94fa));
    repeat (10) @(posedge clk_i);
    check(host_request_ready_o, 1'b1);
    check({transfer_direction_o, exec_phase_o}, 2'b00);
    #1;
    reset_i = 1'b0;
    // unknown opcodes are dropped, so nine of them must not start anything
    repeat (9) put(8'h07);
    host_wr_i = 1'b0;
    @(posedge clk_i);
    #1;
    check(exec_phase_o, 1'b0);
    for (i = 0; i < 6; i++)
      run_cmd(i % 3, 1'(i / 3));
    close_out();
  end
endmodule
`default_nettype wire
